//--- dbpc_params.svh
// register offsets, field positions and reset values for the converter control block
`ifndef DBPC_PARAMS_SVH
`define DBPC_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define DBPC_OFS_DATA_LO    4'h0
`define DBPC_OFS_DATA_HI    4'h1
`define DBPC_OFS_STATUS     4'h2
`define DBPC_OFS_CTRL0      4'h3
`define DBPC_OFS_CTRL1      4'h4
`define DBPC_OFS_PTRCTL     4'h5
`define DBPC_OFS_INDEX      4'h6

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define DBPC_C0_ENABLE      7
`define DBPC_C0_REFSEL      6
`define DBPC_C0_TRGSEL      5
`define DBPC_C0_SWTRG       4
`define DBPC_C0_TOPIE       1
`define DBPC_C0_BOTIE       0
`define DBPC_C1_DMA_REQUEST_ENABLE       7
`define DBPC_C1_MODE        2
`define DBPC_C1_BUFEN       0
`define DBPC_SR_TOP         1
`define DBPC_SR_BOT         0
`define DBPC_PC_PTR_LSB     4

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define DBPC_RST_BYTE       8'h00
`define DBPC_RST_UPPER      1'h1
`define DBPC_RST_STATUS     2'h2

`endif

//--- dbpc_pkg.sv
// types shared by the converter control block
package dbpc_pkg;

  typedef enum logic [1:0] {
    DBPC_RUN,
    DBPC_WAIT,
    DBPC_STOP,
    DBPC_LP_STOP
  } dbpc_power_e;

endpackage

//--- dbpc_core.sv
// digital control of a 12-bit converter with a two-word read-pointer buffer
//
// Contract
// - one control bit picks which of two references feeds the converter
// - enabled converter takes a 12-bit code; one step per code count
// - buffer off: always convert data word zero, pointer ignored
// - buffer on: convert the word at the read pointer
// - any selected trigger with buffer on, outside low-power stop and without a pointer write in the same cycle, advances the pointer per mode
// - changing the buffer mode leaves the pointer unchanged
// - software may write the pointer from zero to the upper limit
// - bottom flag sets when pointer equals the upper limit
// - top flag sets when pointer equals zero
// - normal mode: increment per trigger, wrap from limit to zero
// - one-time scan: increment per trigger, stop at the limit
// - one-time scan with pointer written to limit: triggers do not move it
// - with DMA on, requests replace interrupts; done clears the request
// - with DMA on flags still set and clear when the transfer completes
// - reset restores defaults and holds the converter disabled
// - wait mode: converter runs as in run mode
// - normal stop: converter holds the code present before stop
// - low-power stop: converter fully shut down
// - software trigger bit reads zero; writing one advances once
// - trigger select: zero hardware, one software
// - separate enables gate top and bottom flag interrupts
// - mode bit: zero normal, one one-time scan
`timescale 1ns/1ps
`include "dbpc_params.svh"

module dbpc_core #(
  parameter int DEPTH  = 2,
  parameter int PTR_W  = 1,
  parameter int CODE_W = 12
) (
  // clock and reset
  input  wire logic                 ref_clk_in,
  input  wire logic                 rstn_in,
  // register port
  input  wire logic [3:0]           addr_in,
  input  wire logic [7:0]           wdata_in,
  input  wire logic                 wr_in,
  input  wire logic                 rd_in,
  output logic      [7:0]           rdata_out,
  // trigger, dma and power state
  input  wire logic                 hw_trigger_in,
  input  wire logic                 dma_done_in,
  input  wire logic [1:0]           power_mode_in,
  // converter side
  output logic      [CODE_W-1:0]    code_out,
  output logic                      conv_enable_out,
  output logic                      reference_select_out,
  output logic                      irq_out,
  output logic                      dma_req_out
);

  if (DEPTH != (1 << PTR_W) || CODE_W != 12) begin : g_param_check
    $error("dbpc_core: unsupported parameters");
  end

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  logic [2:0] trg_sync;
  logic [1:0] done_sync;
  logic [1:0] pm_s1;
  logic [1:0] pm_s2;

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      trg_sync  <= 3'h0;
      done_sync <= 2'h0;
      pm_s1     <= 2'h0;
      pm_s2     <= 2'h0;
    end else begin
      trg_sync  <= {trg_sync[1:0], hw_trigger_in};
      done_sync <= {done_sync[0], dma_done_in};
      pm_s1     <= power_mode_in;
      pm_s2     <= pm_s1;
    end
  end

  logic hw_edge;
  logic dma_done;
  dbpc_pkg::dbpc_power_e pmode;
  assign hw_edge  = trg_sync[1] & ~trg_sync[2];
  assign dma_done = done_sync[1];
  assign pmode    = dbpc_pkg::dbpc_power_e'(pm_s2);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [CODE_W-1:0] data_word [DEPTH];
  logic [PTR_W-1:0]  buffer_read_pointer;
  logic [PTR_W-1:0]  buffer_upper_limit;
  logic [PTR_W-1:0]  data_index;
  logic              conv_en;
  logic              reference_select;
  logic              trigger_source_select;
  logic              top_flag_irq_enable;
  logic              bottom_flag_irq_enable;
  logic              dma_request_enable;
  logic              buffer_mode_select;
  logic              buffer_enable_bit;
  logic              pointer_top_flag;
  logic              pointer_bottom_flag;

  function automatic logic is_wr(input logic [3:0] ofs);
    return wr_in && (addr_in == ofs);
  endfunction

  logic sw_trig;
  logic sw_sel;
  logic trig;
  logic ptr_wr;
  assign sw_trig = is_wr(`DBPC_OFS_CTRL0) && wdata_in[`DBPC_C0_SWTRG];
  assign ptr_wr  = is_wr(`DBPC_OFS_PTRCTL);
  // a source select written beside the trigger bit already applies to it
  assign sw_sel  = is_wr(`DBPC_OFS_CTRL0) ? wdata_in[`DBPC_C0_TRGSEL] : trigger_source_select;
  assign trig    = buffer_enable_bit && (sw_sel ? sw_trig : hw_edge) && pmode != dbpc_pkg::DBPC_LP_STOP;

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      conv_en                <= 1'b0;
      reference_select       <= 1'b0;
      trigger_source_select  <= 1'b0;
      top_flag_irq_enable    <= 1'b0;
      bottom_flag_irq_enable <= 1'b0;
    end else if (is_wr(`DBPC_OFS_CTRL0)) begin
      conv_en                <= wdata_in[`DBPC_C0_ENABLE];
      reference_select       <= wdata_in[`DBPC_C0_REFSEL];
      trigger_source_select  <= wdata_in[`DBPC_C0_TRGSEL];
      top_flag_irq_enable    <= wdata_in[`DBPC_C0_TOPIE];
      bottom_flag_irq_enable <= wdata_in[`DBPC_C0_BOTIE];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dma_request_enable <= 1'b0;
      buffer_mode_select <= 1'b0;
      buffer_enable_bit  <= 1'b0;
    end else if (is_wr(`DBPC_OFS_CTRL1)) begin
      dma_request_enable <= wdata_in[`DBPC_C1_DMA_REQUEST_ENABLE];
      buffer_mode_select <= wdata_in[`DBPC_C1_MODE];
      buffer_enable_bit  <= wdata_in[`DBPC_C1_BUFEN];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      data_index <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        data_word[i] <= '0;
      end
    end else begin
      if (is_wr(`DBPC_OFS_INDEX)) begin
        data_index <= wdata_in[PTR_W-1:0];
      end
      if (is_wr(`DBPC_OFS_DATA_LO)) begin
        data_word[data_index][7:0] <= wdata_in;
      end
      if (is_wr(`DBPC_OFS_DATA_HI)) begin
        data_word[data_index][CODE_W-1:8] <= wdata_in[CODE_W-9:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // read pointer
  // ---------------------------------------------------------------
  logic [PTR_W-1:0] next_ptr;
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] wr_lim;
  assign wr_ptr = wdata_in[`DBPC_PC_PTR_LSB +: PTR_W];
  // limit and pointer arrive together; clamp to the new limit so the pointer never exceeds it
  assign wr_lim = wdata_in[PTR_W-1:0];

  always_comb begin
    next_ptr = buffer_read_pointer;
    if (ptr_wr) begin
      next_ptr = (wr_ptr > wr_lim) ? wr_lim : wr_ptr;
    end else if (trig) begin
      if (buffer_read_pointer == buffer_upper_limit) begin
        next_ptr = buffer_mode_select ? buffer_read_pointer : '0;
      end else begin
        next_ptr = buffer_read_pointer + 1'b1;
      end
    end
  end

  // mode writes never touch the pointer
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      buffer_read_pointer <= '0;
      buffer_upper_limit  <= PTR_W'(`DBPC_RST_UPPER);
    end else begin
      buffer_read_pointer <= next_ptr;
      if (ptr_wr) begin
        buffer_upper_limit <= wr_lim;
      end
    end
  end

  // ---------------------------------------------------------------
  // flags: set wins over clear
  // ---------------------------------------------------------------
  logic set_top;
  logic set_bot;
  logic sr_wr;
  assign set_top = trig && next_ptr == '0;
  assign set_bot = trig && next_ptr == buffer_upper_limit;
  assign sr_wr   = is_wr(`DBPC_OFS_STATUS);

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pointer_top_flag    <= 1'(`DBPC_RST_STATUS >> `DBPC_SR_TOP);
      pointer_bottom_flag <= 1'(`DBPC_RST_STATUS >> `DBPC_SR_BOT);
    end else begin
      if (set_top) begin
        pointer_top_flag <= 1'b1;
      end else if ((dma_request_enable && dma_done) || (sr_wr && !wdata_in[`DBPC_SR_TOP])) begin
        pointer_top_flag <= 1'b0;
      end
      if (set_bot) begin
        pointer_bottom_flag <= 1'b1;
      end else if ((dma_request_enable && dma_done) || (sr_wr && !wdata_in[`DBPC_SR_BOT])) begin
        pointer_bottom_flag <= 1'b0;
      end
    end
  end

  logic req;
  assign req = (pointer_top_flag && top_flag_irq_enable) || (pointer_bottom_flag && bottom_flag_irq_enable);

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_out     <= 1'b0;
      dma_req_out <= 1'b0;
    end else begin
      irq_out     <= req && !dma_request_enable;
      dma_req_out <= req && dma_request_enable && !dma_done;
    end
  end

  // ---------------------------------------------------------------
  // converter output
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      code_out             <= '0;
      conv_enable_out      <= 1'b0;
      reference_select_out <= 1'b0;
    end else begin
      reference_select_out <= reference_select;
      case (pmode)
        dbpc_pkg::DBPC_LP_STOP: begin
          conv_enable_out <= 1'b0;
        end
        dbpc_pkg::DBPC_STOP: begin
          conv_enable_out <= conv_en;
        end
        default: begin
          conv_enable_out <= conv_en;
          if (conv_en) begin
            code_out <= buffer_enable_bit ? data_word[buffer_read_pointer] : data_word[0];
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= `DBPC_RST_BYTE;
    end else if (rd_in) begin
      if (addr_in == `DBPC_OFS_DATA_LO) begin
        rdata_out <= data_word[data_index][7:0];
      end else if (addr_in == `DBPC_OFS_DATA_HI) begin
        rdata_out <= 8'({data_word[data_index][CODE_W-1:8]});
      end else if (addr_in == `DBPC_OFS_STATUS) begin
        rdata_out <= {6'h00, pointer_top_flag, pointer_bottom_flag};
      end else if (addr_in == `DBPC_OFS_CTRL0) begin
        rdata_out <= {conv_en, reference_select, trigger_source_select, 3'h0,
                      top_flag_irq_enable, bottom_flag_irq_enable};
      end else if (addr_in == `DBPC_OFS_CTRL1) begin
        rdata_out <= {dma_request_enable, 4'h0, buffer_mode_select, 1'b0, buffer_enable_bit};
      end else if (addr_in == `DBPC_OFS_PTRCTL) begin
        rdata_out <= 8'({buffer_read_pointer, 3'h0, buffer_upper_limit});
      end else if (addr_in == `DBPC_OFS_INDEX) begin
        rdata_out <= 8'(data_index);
      end else begin
        rdata_out <= `DBPC_RST_BYTE;
      end
    end else begin
      rdata_out <= `DBPC_RST_BYTE;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_normal_wrap: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    trig && !ptr_wr && !buffer_mode_select && buffer_read_pointer == buffer_upper_limit
    |=> buffer_read_pointer == '0)
    else $error("pointer did not wrap");
  a_scan_hold: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    trig && !ptr_wr && buffer_mode_select && buffer_read_pointer == buffer_upper_limit
    |=> $stable(buffer_read_pointer))
    else $error("pointer moved past limit");
  a_step_one: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    trig && !ptr_wr && buffer_read_pointer != buffer_upper_limit
    |=> buffer_read_pointer == $past(buffer_read_pointer) + 1'b1)
    else $error("pointer did not step");
  a_mode_keeps: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    !trig && !ptr_wr |=> $stable(buffer_read_pointer))
    else $error("pointer changed without cause");
  a_bottom_set: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    set_bot |=> pointer_bottom_flag)
    else $error("bottom flag missed");
  a_top_set: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    set_top |=> pointer_top_flag)
    else $error("top flag missed");
  a_dma_no_irq: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    dma_request_enable |=> !irq_out)
    else $error("interrupt during dma");
  a_lp_off: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    pmode == dbpc_pkg::DBPC_LP_STOP |=> !conv_enable_out)
    else $error("converter on in low-power stop");
  a_stop_hold: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    pmode == dbpc_pkg::DBPC_STOP |=> $stable(code_out))
    else $error("code changed in stop");
  a_flag_sticky: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    pointer_bottom_flag && !dma_request_enable && !sr_wr |=> pointer_bottom_flag)
    else $error("bottom flag lost");
  a_ref_follows: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    1'b1 |=> reference_select_out == $past(reference_select))
    else $error("reference select not passed on");
  a_code_word_zero: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    conv_en && !buffer_enable_bit && (pmode == dbpc_pkg::DBPC_RUN || pmode == dbpc_pkg::DBPC_WAIT)
    |=> code_out == $past(data_word[0]))
    else $error("code not from word zero");
  a_code_at_ptr: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    conv_en && buffer_enable_bit && (pmode == dbpc_pkg::DBPC_RUN || pmode == dbpc_pkg::DBPC_WAIT)
    |=> code_out == $past(data_word[buffer_read_pointer]))
    else $error("code not from pointer word");
  a_ptr_in_range: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    1'b1 |-> buffer_read_pointer <= buffer_upper_limit)
    else $error("pointer above limit");
  a_done_drops_req: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    dma_done |=> !dma_req_out)
    else $error("dma request kept after done");
  a_dma_clears_flag: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    dma_request_enable && dma_done && !set_bot |=> !pointer_bottom_flag)
    else $error("flag kept after dma done");
  a_sw_trig_zero: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    rd_in && addr_in == `DBPC_OFS_CTRL0 |=> !rdata_out[`DBPC_C0_SWTRG])
    else $error("software trigger bit read as one");
  a_irq_masked: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    !top_flag_irq_enable && !bottom_flag_irq_enable |=> !irq_out)
    else $error("interrupt while both enables off");

endmodule

//--- dbpc_partner.sv
// hardware trigger source and dma controller facing the converter control block
`timescale 1ns/1ps

module dbpc_partner (
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rstn_in,
  // bench control
  input  wire logic fire_in,
  input  wire logic slow_in,
  // block side
  input  wire logic dma_req_in,
  output logic      hw_trigger_out,
  output logic      dma_done_out
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [3:0] hold_cnt;
  logic [3:0] wait_cnt;

  // ---------------------------------------------------------------
  // trigger source
  // ---------------------------------------------------------------
  // pulse held four clocks so the two-stage synchroniser sees one rise
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hold_cnt <= 4'h0;
    end else if (fire_in) begin
      hold_cnt <= 4'h4;
    end else if (hold_cnt != 4'h0) begin
      hold_cnt <= hold_cnt - 4'h1;
    end
  end
  assign hw_trigger_out = (hold_cnt != 4'h0);

  // ---------------------------------------------------------------
  // dma controller
  // ---------------------------------------------------------------
  // done stays high until the request is withdrawn; slow mode answers late
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wait_cnt     <= 4'h0;
      dma_done_out <= 1'h0;
    end else if (!dma_req_in) begin
      wait_cnt     <= 4'h0;
      dma_done_out <= 1'h0;
    end else if (wait_cnt == (slow_in ? 4'hC : 4'h2)) begin
      dma_done_out <= 1'h1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

//--- dbpc_core_tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "dbpc_params.svh"

module dbpc_core_tb_top;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk;
  logic        rstn;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        hw_trig;
  logic        dma_done;
  logic [1:0]  pmode;
  logic [11:0] code;
  logic        conv_en;
  logic        refsel;
  logic        irq;
  logic        dma_req;
  logic        fire;
  logic        slow;
  logic [7:0]  rv;
  int          error_cnt;
  int          checked;
  int          cyc;

  // ---------------------------------------------------------------
  // instances
  // ---------------------------------------------------------------
  dbpc_core #(.DEPTH(2), .PTR_W(1), .CODE_W(12)) uut (
    .ref_clk_in(clk), .rstn_in(rstn), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .hw_trigger_in(hw_trig), .dma_done_in(dma_done), .power_mode_in(pmode),
    .code_out(code), .conv_enable_out(conv_en), .reference_select_out(refsel), .irq_out(irq),
    .dma_req_out(dma_req));
  dbpc_partner partner (
    .ref_clk_in(clk), .rstn_in(rstn), .fire_in(fire), .slow_in(slow), .dma_req_in(dma_req),
    .hw_trigger_out(hw_trig), .dma_done_out(dma_done));

  // ---------------------------------------------------------------
  // clock and timeout
  // ---------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    @(negedge clk);
    rv = rdata;
    chk(what, {4'h0, rv}, {4'h0, exp});
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic swtrg(input logic [7:0] c0);
    wr_reg(`DBPC_OFS_CTRL0, c0 | 8'h10);
    settle(3);
  endtask
  task automatic fire_hw();
    @(posedge clk);
    fire <= 1'h1;
    @(posedge clk);
    fire <= 1'h0;
    settle(8);
  endtask
  task automatic set_power(input logic [1:0] m);
    @(posedge clk);
    pmode <= m;
    settle(5);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk("enable", conv_en, 12'h000);
    chk("code", code, 12'h000);
    chk("irq", irq, 12'h000);
    chk("dma req", dma_req, 12'h000);
    chk_rd(`DBPC_OFS_STATUS, 8'h02, "status");
    chk_rd(`DBPC_OFS_PTRCTL, 8'h01, "ptrctl");
    chk_rd(`DBPC_OFS_CTRL0, 8'h00, "ctrl0");
    chk_rd(`DBPC_OFS_CTRL1, 8'h00, "ctrl1");
    chk_rd(4'hF, 8'h00, "unmapped");
    settle(1);
    chk("rdata idle", {4'h0, rdata}, 12'h000);
    $display("done reset");
  endtask
  task automatic t_direct();
    wr_reg(`DBPC_OFS_INDEX, 8'h00);
    wr_reg(`DBPC_OFS_DATA_LO, 8'hBC);
    wr_reg(`DBPC_OFS_DATA_HI, 8'h0A);
    wr_reg(`DBPC_OFS_INDEX, 8'h01);
    wr_reg(`DBPC_OFS_DATA_LO, 8'h45);
    wr_reg(`DBPC_OFS_DATA_HI, 8'h03);
    wr_reg(`DBPC_OFS_CTRL0, 8'h80);
    settle(3);
    chk("enable", conv_en, 12'h001);
    chk("code word0", code, 12'hABC);
    chk("refsel a", refsel, 12'h000);
    wr_reg(`DBPC_OFS_PTRCTL, 8'h11);
    settle(3);
    chk("code buffer off", code, 12'hABC);
    wr_reg(`DBPC_OFS_CTRL0, 8'hC0);
    settle(3);
    chk("refsel b", refsel, 12'h001);
    $display("done direct");
  endtask
  task automatic t_modes();
    wr_reg(`DBPC_OFS_CTRL1, 8'h01);
    settle(3);
    chk("code ptr1", code, 12'h345);
    wr_reg(`DBPC_OFS_PTRCTL, 8'h01);
    settle(3);
    chk("code ptr0", code, 12'hABC);
    swtrg(8'hA0);
    chk("code after sw", code, 12'h345);
    chk_rd(`DBPC_OFS_CTRL0, 8'hA0, "swtrig reads");
    swtrg(8'hA0);
    chk("code wrap", code, 12'hABC);
    wr_reg(`DBPC_OFS_CTRL1, 8'h05);
    chk_rd(`DBPC_OFS_PTRCTL, 8'h01, "ptr mode chg");
    swtrg(8'hA0);
    swtrg(8'hA0);
    chk("code scan stop", code, 12'h345);
    chk_rd(`DBPC_OFS_PTRCTL, 8'h11, "ptr scan stop");
    wr_reg(`DBPC_OFS_PTRCTL, 8'h11);
    swtrg(8'hA0);
    chk_rd(`DBPC_OFS_PTRCTL, 8'h11, "ptr at limit");
    wr_reg(`DBPC_OFS_PTRCTL, 8'h01);
    swtrg(8'hA0);
    chk_rd(`DBPC_OFS_PTRCTL, 8'h11, "ptr climbs");
    wr_reg(`DBPC_OFS_CTRL1, 8'h01);
    chk_rd(`DBPC_OFS_PTRCTL, 8'h11, "ptr back normal");
    swtrg(8'h80);
    chk_rd(`DBPC_OFS_PTRCTL, 8'h11, "sw ignored hw sel");
    $display("done modes");
  endtask
  task automatic t_flags();
    wr_reg(`DBPC_OFS_CTRL0, 8'hA1);
    wr_reg(`DBPC_OFS_STATUS, 8'h00);
    settle(3);
    chk("irq cleared", irq, 12'h000);
    swtrg(8'hA1);
    chk("irq top masked", irq, 12'h000);
    chk_rd(`DBPC_OFS_STATUS, 8'h02, "top flag");
    swtrg(8'hA1);
    chk("irq bottom", irq, 12'h001);
    chk_rd(`DBPC_OFS_STATUS, 8'h03, "bottom flag");
    settle(5);
    chk("irq holds", irq, 12'h001);
    wr_reg(`DBPC_OFS_STATUS, 8'h02);
    settle(3);
    chk("irq bottom cleared", irq, 12'h000);
    wr_reg(`DBPC_OFS_CTRL0, 8'hA2);
    settle(3);
    chk("irq top enabled", irq, 12'h001);
    wr_reg(`DBPC_OFS_STATUS, 8'h00);
    settle(3);
    chk("irq all cleared", irq, 12'h000);
    $display("done flags");
  endtask
  task automatic t_hw();
    wr_reg(`DBPC_OFS_CTRL0, 8'h80);
    fire_hw();
    chk_rd(`DBPC_OFS_PTRCTL, 8'h01, "hw advance");
    chk("code hw", code, 12'hABC);
    wr_reg(`DBPC_OFS_CTRL0, 8'hA0);
    fire_hw();
    chk_rd(`DBPC_OFS_PTRCTL, 8'h01, "hw ignored sw sel");
    $display("done hw");
  endtask
  task automatic t_dma();
    int n;
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      slow <= s[0];
      wr_reg(`DBPC_OFS_CTRL1, 8'h81);
      wr_reg(`DBPC_OFS_CTRL0, 8'hA3);
      wr_reg(`DBPC_OFS_STATUS, 8'h00);
      wr_reg(`DBPC_OFS_CTRL0, 8'hB3);
      n = 0;
      while (dma_req !== 1'h1 && n < 20) begin
        settle(1);
        n++;
      end
      chk("dma req", dma_req, 12'h001);
      chk("irq with dma", irq, 12'h000);
      chk_rd(`DBPC_OFS_STATUS, (s == 0) ? 8'h01 : 8'h02, "flag with dma");
      n = 0;
      while (dma_req !== 1'h0 && n < 40) begin
        settle(1);
        n++;
      end
      chk("dma req cleared", dma_req, 12'h000);
      chk_rd(`DBPC_OFS_STATUS, 8'h00, "flags dma cleared");
    end
    wr_reg(`DBPC_OFS_CTRL1, 8'h01);
    $display("done dma");
  endtask
  task automatic t_power();
    set_power(2'h1);
    swtrg(8'hA0);
    chk("code wait", code, 12'h345);
    set_power(2'h2);
    swtrg(8'hA0);
    chk("code held stop", code, 12'h345);
    chk("enable stop", conv_en, 12'h001);
    set_power(2'h3);
    chk("enable lp stop", conv_en, 12'h000);
    set_power(2'h0);
    chk("enable run", conv_en, 12'h001);
    chk("code run", code, 12'hABC);
    @(posedge clk);
    rstn <= 1'h0;
    settle(2);
    chk("enable in reset", conv_en, 12'h000);
    @(posedge clk);
    rstn <= 1'h1;
    chk_rd(`DBPC_OFS_CTRL0, 8'h00, "ctrl0 after reset");
    $display("done power");
  endtask

  // ---------------------------------------------------------------
  // closing and main sequence
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    {addr, wdata, wr, rd, fire, slow} = '0;
    pmode     = 2'h0;
    rstn      = 1'h0;
    error_cnt = 0;
    checked   = 0;
    cyc       = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    settle(1);
    t_reset();
    t_direct();
    t_modes();
    t_flags();
    t_hw();
    t_dma();
    t_power();
    report_and_stop();
  end
endmodule
